// file: bench/smc_far_model.sv
// Far-side model: CPU program counter and interrupt latch
`timescale 1ns/1ns
module smc_far_model (
	input wire core_clk,
	input wire rst_n,
	input wire cpu_halt,
	input wire resume_valid,
	input wire irq_src,
	output logic [15:0] cpu_pc,
	output logic irq_pending
);
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_pc <= 16'h0100;
			irq_pending <= 1'b0;
		end else begin
			if (!cpu_halt)
				cpu_pc <= cpu_pc + 16'h0002;
			// The resume pulse clears the waking latch; a new irq_src in the same cycle wins
			if (irq_src)
				irq_pending <= 1'b1;
			else if (resume_valid)
				irq_pending <= 1'b0;
		end
	end
endmodule

// file: bench/smc_standby_ctrl_sva.sv
// Checker for the standby controller ports
`timescale 1ns/1ns
module smc_standby_ctrl_sva (
	input wire core_clk,
	input wire rst_n,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire wake_pin,
	input wire wdt_irq,
	input wire irq_pending,
	input wire master_irq_enable,
	input wire cpu_halt,
	input wire wdt_halt,
	input wire periph_halt,
	input wire hosc_en,
	input wire losc_en,
	input wire tg_clear,
	input wire irq_service,
	input wire resume_valid
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire doze_wr = reg_wr && reg_addr == 4'h1 && reg_wdata[4] && !cpu_halt;
	halt_entry_a: assert property (reg_wr && reg_addr == 4'h0 &&
		reg_wdata[7] && !cpu_halt |=> cpu_halt) else $error("halt entry");
	stop_state_a: assert property (tg_clear |->
		!hosc_en && cpu_halt && periph_halt) else $error("stop state");
	warm_start_a: assert property ($fell(tg_clear) |->
		(hosc_en || losc_en) && cpu_halt) else $error("warm start");
	edge_wake_a: assert property (tg_clear && $rose(wake_pin) |->
		##[1:5] !tg_clear) else $error("edge wake");
	doze_entry_a: assert property (doze_wr && !wdt_irq &&
		!irq_pending |=> cpu_halt && wdt_halt && !periph_halt)
		else $error("doze entry");
	wdt_block_a: assert property (doze_wr && wdt_irq |=>
		!cpu_halt) else $error("wdt block");
	doze_wake_a: assert property (cpu_halt && !periph_halt &&
		irq_pending |-> ##[1:4] resume_valid) else $error("doze wake");
	irq_serve_a: assert property (irq_service |->
		$past(master_irq_enable)) else $error("irq serve");
endmodule
bind smc_standby_ctrl smc_standby_ctrl_sva i_smc_standby_ctrl_sva (.*);

// file: bench/smc_standby_ctrl_tb_top.sv
// Self-checking bench for the standby controller
`timescale 1ns/1ns
module smc_standby_ctrl_tb_top;
	logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic wake_pin = 1'b0, master_irq_enable = 1'b0, wdt_irq = 1'b0;
	logic irq_src = 1'b0, sv;
	logic [3:0] reg_addr = 4'h0, key_wakeup_in = 4'hf;
	logic [7:0] reg_wdata = 8'h00, d;
	logic [15:0] pc_at;
	wire [7:0] reg_rdata;
	wire [15:0] cpu_pc, resume_pc;
	wire cpu_halt, wdt_halt, periph_halt, hosc_en, losc_en, tg_clear;
	wire irq_service, resume_valid, irq_pending;
	int n_errors = 0, samples_checked = 0, cyc = 0, n;
	smc_standby_ctrl #(.KEYS(4), .WU_CYC_00(48), .WU_CYC_01(16),
		.WU_CYC_10(12), .WU_CYC_11(4)) i_smc_standby_ctrl (.*);
	smc_far_model i_smc_far_model (.*);
	always #2 core_clk = ~core_clk;
	function automatic int wu(input logic [1:0] u);
		return u == 2'h0 ? 48 : u == 2'h1 ? 16 : u == 2'h2 ? 12 : 4;
	endfunction
	function automatic logic [1:0] osc(input logic dual, input logic slow);
		return dual ? {~slow, 1'b1} : 2'b10;
	endfunction
	task results;
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task tick(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		pc_at = cpu_pc;
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		chk("rdata", {8'h00, e}, {8'h00, reg_rdata});
	endtask
	task wait_res;
		n = 0;
		sv = 1'b0;
		while (resume_valid !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			n++;
			sv = sv | irq_service;
		end
	endtask
	task deep(input logic [1:0] u, input logic lvl);
		wr(4'h0, {1'b1, lvl, u, 4'h0});
		tick(2);
		chk("stop", 16'h5, {tg_clear, hosc_en, cpu_halt});
		key_wakeup_in <= 4'($urandom_range(0, 14));
		if (!lvl) begin
			tick(6);
			chk("edge key", 16'h1, tg_clear);
			wake_pin <= 1'b1;
		end
		wait_res;
		chk("warmup", 16'h1, n >= wu(u) && n <= wu(u) + 10);
		chk("resume pc", pc_at + 16'h0002, resume_pc);
		wake_pin <= 1'b0;
		key_wakeup_in <= 4'hf;
		rd(4'h0, {1'b0, lvl, u, 4'h0});
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			n_errors++;
			results;
		end
	end
	initial begin
		void'($urandom(32'h1817));
		tick(8);
		rst_n <= 1'b1;
		tick(1);
		rd(4'h1, 8'h80);
		d = 8'($urandom);
		wr(4'h2, d);
		rd(4'h2, d);
		wr(4'h2, 8'h0f);
		for (int w = 0; w < 8; w++) begin
			wr(4'h1, {2'b10, w[0], 4'h0, w[1]});
			deep(w[1:0], w[2]);
			chk("osc", {14'h0, osc(w[1], w[0])}, {14'h0, hosc_en, losc_en});
		end
		wake_pin <= 1'b1;
		tick(3);
		wr(4'h0, 8'hf0);
		tick(2);
		chk("no stop", 16'h1, {tg_clear, cpu_halt});
		wait_res;
		chk("skip", 16'h1, n <= 12);
		wake_pin <= 1'b0;
		for (int m = 0; m < 2; m++) begin
			master_irq_enable <= m[0];
			wr(4'h1, 8'h90);
			tick(2);
			chk("doze", 16'h6, {cpu_halt, wdt_halt, periph_halt});
			rd(4'h3, 8'h08);
			irq_src <= 1'b1;
			tick(1);
			irq_src <= 1'b0;
			wait_res;
			chk("service", {15'h0, m[0]}, {15'h0, sv});
			chk("doze pc", pc_at + 16'h0002, resume_pc);
			rd(4'h1, 8'h80);
		end
		wdt_irq <= 1'b1;
		wr(4'h1, 8'h90);
		tick(2);
		chk("wdt block", 16'h0, cpu_halt);
		wdt_irq <= 1'b0;
		wr(4'h0, 8'h80);
		tick(3);
		rst_n <= 1'b0;
		tick(1);
		chk("reset", 16'h1, {cpu_halt, hosc_en});
		rst_n <= 1'b1;
		tick(1);
		rd(4'h0, 8'h00);
		results;
	end
endmodule

// file: core/smc_consts.vh
// Register map, field positions, reset values and timing counts
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH
`define SMC_ADDR_W 4
`define SMC_OFS_CTRL1 4'h0
`define SMC_OFS_CTRL2 4'h1
`define SMC_OFS_WAKEEN 4'h2
`define SMC_OFS_STATUS 4'h3
`define SMC_OFS_PC 4'h4
`define SMC_OFS_PREDIV 4'h5
`define SMC_C1_HALT 7
`define SMC_C1_RELEASE_MODE_SELECT 6
`define SMC_C1_WUT_HI 5
`define SMC_C1_WUT_LO 4
`define SMC_C2_HOSC 7
`define SMC_C2_LOSC 6
`define SMC_C2_SLOWCK 5
`define SMC_C2_DOZE 4
`define SMC_C2_DUAL 0
`define SMC_CTRL1_RST 8'h00
`define SMC_CTRL2_RST 8'h80
`define SMC_WAKEEN_RST 8'h00
`define SMC_PC_STEP 16'h0002
`define SMC_CLK_MHZ 250
`define SMC_BASIC_MHZ 16
`define SMC_WU_MS_01 4.096
`define SMC_WU_MS_11 1.024
// Warm-up counts at core_clk, derived from the 16 MHz figures
`define SMC_WU_CYC_01 (4096 * `SMC_CLK_MHZ)
`define SMC_WU_CYC_11 (1024 * `SMC_CLK_MHZ)
`define SMC_WU_CYC_00 (12288 * `SMC_CLK_MHZ)
`define SMC_WU_CYC_10 (3072 * `SMC_CLK_MHZ)
`define SMC_ST_RUN 2'd0
`define SMC_ST_STOP 2'd1
`define SMC_ST_WARM 2'd2
`define SMC_ST_DOZE 2'd3
`endif

// file: core/smc_standby_ctrl.v
// Standby mode controller: deep halt, warm-up and CPU doze
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "smc_consts.vh"

module smc_standby_ctrl #(
	parameter KEYS = 4,
	parameter WU_CYC_00 = `SMC_WU_CYC_00,
	parameter WU_CYC_01 = `SMC_WU_CYC_01,
	parameter WU_CYC_10 = `SMC_WU_CYC_10,
	parameter WU_CYC_11 = `SMC_WU_CYC_11
) (
	input wire core_clk,
	input wire rst_n,
	input wire [`SMC_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire [15:0] cpu_pc,
	input wire master_irq_enable,
	input wire irq_pending,
	input wire wdt_irq,
	input wire wake_pin,
	input wire [KEYS-1:0] key_wakeup_in,
	output reg cpu_halt,
	output reg wdt_halt,
	output reg periph_halt,
	output reg hosc_en,
	output reg losc_en,
	output reg tg_clear,
	output reg irq_service,
	output reg resume_valid,
	output reg [15:0] resume_pc
);
	localparam ST_RUN = 4'b0001;
	localparam ST_STOP = 4'b0010;
	localparam ST_WARM = 4'b0100;
	localparam ST_DOZE = 4'b1000;

	reg [7:0] ctrl1_reg;
	reg [7:0] ctrl2_reg;
	reg [7:0] wakeen_reg;
	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [22:0] wu_cnt_reg;
	reg [7:0] prediv_reg;
	reg [15:0] pc_hold_reg;
	reg wake_s1_reg;
	reg wake_s2_reg;
	reg wake_prev_reg;
	reg [22:0] wu_load;
	reg [7:0] rdata_next;
	reg hosc_next;
	reg losc_next;

	wire [KEYS-1:0] key_chg;
	wire release_mode_select;
	wire wake_rise;
	wire key_edge;
	wire release_cond;
	wire sel_ctrl1;
	wire sel_ctrl2;
	wire sel_wakeen;
	wire halt_wr;
	wire doze_wr;
	wire doze_ok;
	wire wake;
	wire in_run;
	wire in_stop;
	wire in_warm;
	wire in_doze;
	wire wu_done;
	wire enter_warm;
	wire leave_warm;
	wire leave_doze;
	wire leave_standby;
	wire reg_wr_ok;

	assign in_run = (state_reg == ST_RUN);
	assign in_stop = (state_reg == ST_STOP);
	assign in_warm = (state_reg == ST_WARM);
	assign in_doze = (state_reg == ST_DOZE);
	assign enter_warm = (state_next == ST_WARM) &&
		!in_warm;
	assign leave_warm = in_warm &&
		(state_next == ST_RUN);
	assign leave_doze = in_doze &&
		(state_next == ST_RUN);
	assign leave_standby = !in_run &&
		(state_next == ST_RUN);
	// Count ends on one so warm-up lasts exactly the load
	assign wu_done = (wu_cnt_reg == 23'd1);

	// Software can only write while the CPU runs
	assign reg_wr_ok = reg_wr && in_run;
	assign sel_ctrl1 = (reg_addr == `SMC_OFS_CTRL1);
	assign sel_ctrl2 = (reg_addr == `SMC_OFS_CTRL2);
	assign sel_wakeen = (reg_addr == `SMC_OFS_WAKEEN);
	assign halt_wr = reg_wr_ok & sel_ctrl1 &
		reg_wdata[`SMC_C1_HALT];
	assign doze_wr = reg_wr_ok & sel_ctrl2 &
		reg_wdata[`SMC_C2_DOZE];
	// A watchdog irq just before entry wins over the doze request
	assign doze_ok = doze_wr & ~wdt_irq;
	assign wake = irq_pending;

	assign release_mode_select = ctrl1_reg[`SMC_C1_RELEASE_MODE_SELECT];
	assign wake_rise = wake_s2_reg & ~wake_prev_reg;
	assign key_edge = |key_chg;
	// Keys ignored in edge mode
	assign release_cond = release_mode_select ? (wake_s2_reg | key_edge) :
		wake_rise;

	// Two-flop synchroniser for the wake pin
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_s1_reg <= 1'b0;
			wake_s2_reg <= 1'b0;
			wake_prev_reg <= 1'b0;
		end else begin
			wake_s1_reg <= wake_pin;
			wake_s2_reg <= wake_s1_reg;
			wake_prev_reg <= wake_s2_reg;
		end
	end

	// Key pins idle high, so a high reset avoids a false edge
	genvar k;
	generate
		for (k = 0; k < KEYS; k = k + 1) begin : g_key
			reg s1_reg;
			reg s2_reg;
			reg prev_reg;

			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_reg <= 1'b1;
					s2_reg <= 1'b1;
					prev_reg <= 1'b1;
				end else begin
					s1_reg <= key_wakeup_in[k];
					s2_reg <= s1_reg;
					prev_reg <= s2_reg;
				end
			end

			// Either polarity counts, gated by its enable bit
			assign key_chg[k] = (s2_reg ^ prev_reg) & wakeen_reg[k];
		end
	endgenerate

	// Warm-up lengths in core clock cycles
	always @* begin
		case (ctrl1_reg[`SMC_C1_WUT_HI:`SMC_C1_WUT_LO])
		2'b00: wu_load = WU_CYC_00[22:0];
		2'b01: wu_load = WU_CYC_01[22:0];
		2'b10: wu_load = WU_CYC_10[22:0];
		default: wu_load = WU_CYC_11[22:0];
		endcase
	end

	// Release mode comes from the halt write itself
	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_RUN: begin
			if (halt_wr) begin
				if (reg_wdata[`SMC_C1_RELEASE_MODE_SELECT] & wake_s2_reg) begin
					state_next = ST_WARM;
				end else begin
					state_next = ST_STOP;
				end
			end else if (doze_ok) begin
				state_next = ST_DOZE;
			end
		end
		ST_STOP: begin
			if (release_cond) begin
				state_next = ST_WARM;
			end
		end
		ST_WARM: begin
			if (wu_done) begin
				state_next = ST_RUN;
			end
		end
		ST_DOZE: begin
			if (wake) begin
				state_next = ST_RUN;
			end
		end
		default: state_next = ST_RUN;
		endcase
	end

	// Reset low ends any standby at once via the async clear
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			state_reg <= ST_RUN;
		else
			state_reg <= state_next;
	end

	// Prescaler runs only in normal operation
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			prediv_reg <= 8'h00;
		else if (in_stop)
			prediv_reg <= 8'h00;
		else if (in_run)
			prediv_reg <= prediv_reg + 8'h01;
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			pc_hold_reg <= 16'h0000;
		else if (halt_wr || doze_wr)
			pc_hold_reg <= cpu_pc + `SMC_PC_STEP;
	end

	// Warm-up down-counter, loaded on the way into warm-up
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			wu_cnt_reg <= 23'd0;
		else if (enter_warm)
			wu_cnt_reg <= wu_load;
		else if (in_warm)
			wu_cnt_reg <= wu_cnt_reg - 23'd1;
	end

	// Halt bit drops by itself once warm-up is over
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			ctrl1_reg <= `SMC_CTRL1_RST;
		else if (reg_wr_ok && sel_ctrl1)
			ctrl1_reg <= reg_wdata;
		else if (leave_warm)
			ctrl1_reg[`SMC_C1_HALT] <= 1'b0;
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			ctrl2_reg <= `SMC_CTRL2_RST;
		else if (reg_wr_ok && sel_ctrl2)
			ctrl2_reg <= reg_wdata;
		else if (leave_doze)
			ctrl2_reg[`SMC_C2_DOZE] <= 1'b0;
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			wakeen_reg <= `SMC_WAKEEN_RST;
		else if (reg_wr_ok && sel_wakeen)
			wakeen_reg <= reg_wdata;
	end

	// Read data stand for one cycle only
	always @* begin
		rdata_next = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
			`SMC_OFS_CTRL1: rdata_next = ctrl1_reg;
			`SMC_OFS_CTRL2: rdata_next = ctrl2_reg;
			`SMC_OFS_WAKEEN: rdata_next = wakeen_reg;
			`SMC_OFS_STATUS: rdata_next = {4'h0, state_reg};
			`SMC_OFS_PC: rdata_next = pc_hold_reg[7:0];
			`SMC_OFS_PREDIV: rdata_next = prediv_reg;
			default: rdata_next = 8'h00;
			endcase
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= rdata_next;
	end

	// Held state is frozen by halting clocks, not copied
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_halt <= 1'b0;
			wdt_halt <= 1'b0;
		end else begin
			cpu_halt <= (state_next != ST_RUN);
			wdt_halt <= (state_next != ST_RUN);
		end
	end

	// Peripherals keep running in doze
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_halt <= 1'b0;
			tg_clear <= 1'b0;
		end else begin
			periph_halt <= (state_next == ST_STOP) ||
				(state_next == ST_WARM);
			tg_clear <= (state_next == ST_STOP);
		end
	end

	// Oscillator choice on release follows the clock mode bits
	always @* begin
		hosc_next = hosc_en;
		losc_next = losc_en;
		if (state_next == ST_STOP) begin
			hosc_next = 1'b0;
			losc_next = 1'b0;
		end else if (in_stop) begin
			if (ctrl2_reg[`SMC_C2_DUAL]) begin
				hosc_next = ~ctrl2_reg[`SMC_C2_SLOWCK];
				losc_next = 1'b1;
			end else begin
				hosc_next = 1'b1;
				losc_next = 1'b0;
			end
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hosc_en <= 1'b1;
			losc_en <= 1'b0;
		end else begin
			hosc_en <= hosc_next;
			losc_en <= losc_next;
		end
	end

	// Resume pulse and address leave together
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			resume_valid <= 1'b0;
			resume_pc <= 16'h0000;
		end else begin
			resume_valid <= leave_standby;
			if (leave_standby)
				resume_pc <= pc_hold_reg;
		end
	end

	// Master enable decides whether the waking irq is taken
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			irq_service <= 1'b0;
		else
			irq_service <= in_doze && wake &&
				master_irq_enable;
	end
endmodule
